// ### logic/rdpc_top.sv
// Overview of operation
// R1 - Bit 7 selects bit-error measurement mode
// R2 - Bit 3 freezes symbol timing after SFD
// R3 - Bit 2 bypasses frequency-correction limiter
// R4 - Bit 1 stops correction after SFD
// R5 - Bit 0 disables frequency correction
// R6 - Signal level offset, add or subtract
// R7 - Bit 5 exposes digital temperature readback
// R8 - Bits 4/0 route temperature/level to monitor
// R9 - Software never enables two monitor outputs
// R10 - Three gain registers, nibbles reset 0111
// R11 - Select field picks gain set one-three
// R12 - Bit 4 picks high or low amplifier
// R13 - Bit 7 picks transmit or amplifier timing
// R14 - Bit 6 inverts external control output
// R15 - Bit 5 picks push-pull or open-drain
// R16 - Enable bit gates output, else low
// R17 - Reserved bits store, read back, no effect
//
// Added by the designer: register access over AXI4-Lite.
`include "rdpc_consts.svh"

module rdpc_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // AXI4-Lite write address
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_AWADDR,
  // AXI4-Lite write data
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read address
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [31:0] I_ARADDR,
  // AXI4-Lite read data
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Radio state inputs
  input wire logic I_RX_ACTIVE,
  input wire logic I_SFD_DET,
  input wire logic I_TX_ON,
  input wire logic I_AMP_ON,
  input wire logic [7:0] I_SIGNAL_LEVEL,
  input wire logic [7:0] I_TEMP_CONV,
  // Demodulator controls
  output logic O_BIT_ERROR_MEASURE_MODE,
  output logic O_SYMBOL_TIMING_RUN,
  output logic O_FREQ_CORR_LIMITER_EN,
  output logic O_FREQ_CORR_RUN,
  output logic [7:0] O_SIGNAL_LEVEL_ADJ,
  // Analog monitor
  output logic O_TEMP_ANALOG_OUT_EN,
  output logic O_SIGNAL_LEVEL_ANALOG_OUT_EN,
  output logic O_RX_NOT_GUARANTEED,
  // Amplifier
  output logic O_AMPLIFIER_CHOICE,
  output logic [3:0] O_GAIN_CODE,
  // External amplifier control pin
  output logic O_EXTERNAL_AMP_CONTROL_OUT,
  output logic O_EXTERNAL_AMP_CONTROL_OE
);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old_v;
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx >= `RDPC_IDX_DEMOD) && (idx <= `RDPC_IDX_TEMP);
  endfunction

  function automatic logic is_writable(input logic [7:0] idx);
    is_writable = (idx >= `RDPC_IDX_DEMOD) && (idx <= `RDPC_IDX_EXT_EN);
  endfunction

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  rdpc_pkg::rdpc_byte_t demod_q;
  rdpc_pkg::rdpc_byte_t lvl_ofs_q;
  rdpc_pkg::rdpc_byte_t mon_out_q;
  rdpc_pkg::rdpc_byte_t gain_q [3];
  rdpc_pkg::rdpc_byte_t amp_ctrl_q;
  rdpc_pkg::rdpc_byte_t ext_en_q;
  rdpc_pkg::rdpc_byte_t temp_q;

  // --------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------
  rdpc_pkg::rdpc_wr_state_e wr_state_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [7:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  always_comb begin
    wr_idx = aw_got_q ? aw_idx_q : word_index(I_AWADDR);
    wr_data = w_got_q ? w_data_q : I_WDATA;
    wr_strb = w_got_q ? w_strb_q : I_WSTRB;
    do_write = (wr_state_q == rdpc_pkg::RDPC_W_IDLE) &&
               (aw_got_q || (I_AWVALID && O_AWREADY)) &&
               (w_got_q || (I_WVALID && O_WREADY));
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wr_state_q <= rdpc_pkg::RDPC_W_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_idx_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `RDPC_RESP_OKAY;
    end else begin
      case (wr_state_q)
        rdpc_pkg::RDPC_W_IDLE: begin
          if (do_write) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            O_AWREADY <= 1'b0;
            O_WREADY <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP <= is_writable(wr_idx) ? `RDPC_RESP_OKAY :
                       `RDPC_RESP_SLVERR;
            wr_state_q <= rdpc_pkg::RDPC_W_RESP;
          end else begin
            if (I_AWVALID && O_AWREADY) begin
              aw_got_q <= 1'b1;
              aw_idx_q <= word_index(I_AWADDR);
              O_AWREADY <= 1'b0;
            end
            if (I_WVALID && O_WREADY) begin
              w_got_q <= 1'b1;
              w_data_q <= I_WDATA;
              w_strb_q <= I_WSTRB;
              O_WREADY <= 1'b0;
            end
          end
        end
        rdpc_pkg::RDPC_W_RESP: begin
          if (I_BREADY) begin
            O_BVALID <= 1'b0;
            O_AWREADY <= 1'b1;
            O_WREADY <= 1'b1;
            wr_state_q <= rdpc_pkg::RDPC_W_IDLE;
          end
        end
        default: begin
          wr_state_q <= rdpc_pkg::RDPC_W_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Register storage (all bits, reserved included, read back)
  // --------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      demod_q <= `RDPC_RST_DEMOD;
      lvl_ofs_q <= `RDPC_RST_LVL_OFS;
      mon_out_q <= `RDPC_RST_MON_OUT;
      gain_q[0] <= `RDPC_RST_GAIN; // R10
      gain_q[1] <= `RDPC_RST_GAIN;
      gain_q[2] <= `RDPC_RST_GAIN;
      amp_ctrl_q <= `RDPC_RST_AMP_CTRL; // R12
      ext_en_q <= `RDPC_RST_EXT_EN;
    end else if (do_write) begin
      case (wr_idx)
        `RDPC_IDX_DEMOD: demod_q <= merge_byte(demod_q, wr_data, wr_strb);
        `RDPC_IDX_LVL_OFS: begin
          lvl_ofs_q <= merge_byte(lvl_ofs_q, wr_data, wr_strb);
        end
        `RDPC_IDX_MON_OUT: begin
          mon_out_q <= merge_byte(mon_out_q, wr_data, wr_strb);
        end
        `RDPC_IDX_GAIN1: gain_q[0] <= merge_byte(gain_q[0], wr_data, wr_strb);
        `RDPC_IDX_GAIN2: gain_q[1] <= merge_byte(gain_q[1], wr_data, wr_strb);
        `RDPC_IDX_GAIN3: gain_q[2] <= merge_byte(gain_q[2], wr_data, wr_strb);
        `RDPC_IDX_AMP_CTRL: begin
          amp_ctrl_q <= merge_byte(amp_ctrl_q, wr_data, wr_strb); // R17
        end
        `RDPC_IDX_EXT_EN: ext_en_q <= merge_byte(ext_en_q, wr_data, wr_strb);
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Temperature readback
  // --------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      temp_q <= 8'h00;
    end else if (mon_out_q[`RDPC_B_TEMP_DIG]) begin
      temp_q <= I_TEMP_CONV; // R7
    end
  end

  // --------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic [7:0] status;

  always_comb begin
    status = {5'h00, O_EXTERNAL_AMP_CONTROL_OUT, O_FREQ_CORR_RUN,
              O_SYMBOL_TIMING_RUN};
    rd_idx = word_index(I_ARADDR);
    case (rd_idx)
      `RDPC_IDX_DEMOD: rd_byte = demod_q;
      `RDPC_IDX_LVL_OFS: rd_byte = lvl_ofs_q;
      `RDPC_IDX_MON_OUT: rd_byte = mon_out_q;
      `RDPC_IDX_GAIN1: rd_byte = gain_q[0];
      `RDPC_IDX_GAIN2: rd_byte = gain_q[1];
      `RDPC_IDX_GAIN3: rd_byte = gain_q[2];
      `RDPC_IDX_AMP_CTRL: rd_byte = amp_ctrl_q;
      `RDPC_IDX_EXT_EN: rd_byte = ext_en_q;
      `RDPC_IDX_STATUS: rd_byte = status;
      `RDPC_IDX_TEMP: rd_byte = temp_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `RDPC_RESP_OKAY;
    end else if (O_RVALID) begin
      if (I_RREADY) begin
        O_RVALID <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RDATA <= {24'h00_0000, rd_byte};
      O_RRESP <= is_mapped(rd_idx) ? `RDPC_RESP_OKAY : `RDPC_RESP_SLVERR;
    end
  end

  // --------------------------------------------------------------
  // Demodulator control
  // --------------------------------------------------------------
  logic sym_run;
  logic afc_run;

  rdpc_track_gate u_symbol_gate (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_rx_active(I_RX_ACTIVE),
    .i_sfd_det(I_SFD_DET),
    .i_stop_after_sfd(demod_q[`RDPC_B_STR_FREEZE]),
    .i_disable(1'b0),
    .o_run(sym_run)
  );

  rdpc_track_gate u_afc_gate (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_rx_active(I_RX_ACTIVE),
    .i_sfd_det(I_SFD_DET),
    .i_stop_after_sfd(demod_q[`RDPC_B_AFC_STOP]),
    .i_disable(demod_q[`RDPC_B_AFC_DIS]),
    .o_run(afc_run)
  );

  logic [8:0] lvl_sum;

  always_comb begin
    if (lvl_ofs_q[`RDPC_B_OFS_DIR]) begin
      lvl_sum = {1'b0, I_SIGNAL_LEVEL} + {4'h0, lvl_ofs_q[4:0]}; // R6
    end else begin
      lvl_sum = {1'b0, I_SIGNAL_LEVEL} - {4'h0, lvl_ofs_q[4:0]};
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_BIT_ERROR_MEASURE_MODE <= 1'b0;
      O_SYMBOL_TIMING_RUN <= 1'b1;
      O_FREQ_CORR_LIMITER_EN <= 1'b1;
      O_FREQ_CORR_RUN <= 1'b1;
      O_SIGNAL_LEVEL_ADJ <= 8'h00;
    end else begin
      O_BIT_ERROR_MEASURE_MODE <= demod_q[`RDPC_B_BER]; // R1
      O_SYMBOL_TIMING_RUN <= sym_run; // R2
      O_FREQ_CORR_LIMITER_EN <= !demod_q[`RDPC_B_LIM_DIS]; // R3
      O_FREQ_CORR_RUN <= afc_run; // R4 R5
      if (lvl_sum[8]) begin
        O_SIGNAL_LEVEL_ADJ <= lvl_ofs_q[`RDPC_B_OFS_DIR] ? 8'hff : 8'h00;
      end else begin
        O_SIGNAL_LEVEL_ADJ <= lvl_sum[7:0];
      end
    end
  end

  // --------------------------------------------------------------
  // Monitor and amplifier selection
  // --------------------------------------------------------------
  rdpc_pkg::rdpc_gain_sel_e gain_sel;
  logic [7:0] gain_pair;

  always_comb begin
    gain_sel = rdpc_pkg::rdpc_gain_sel_e'(amp_ctrl_q[1:0]);
    case (gain_sel)
      rdpc_pkg::RDPC_SEL_ONE: gain_pair = gain_q[0]; // R11
      rdpc_pkg::RDPC_SEL_TWO: gain_pair = gain_q[1];
      rdpc_pkg::RDPC_SEL_THREE: gain_pair = gain_q[2];
      default: gain_pair = gain_q[2];
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TEMP_ANALOG_OUT_EN <= 1'b0;
      O_SIGNAL_LEVEL_ANALOG_OUT_EN <= 1'b0;
      O_RX_NOT_GUARANTEED <= 1'b0;
      O_AMPLIFIER_CHOICE <= 1'b1;
      O_GAIN_CODE <= 4'h7;
    end else begin
      // Two enables at once give no correct value (software's duty) R9
      O_TEMP_ANALOG_OUT_EN <= mon_out_q[`RDPC_B_TEMP_ANA]; // R8
      O_SIGNAL_LEVEL_ANALOG_OUT_EN <= mon_out_q[`RDPC_B_RSSI_ANA];
      O_RX_NOT_GUARANTEED <= mon_out_q[`RDPC_B_TEMP_DIG]; // R7
      O_AMPLIFIER_CHOICE <= amp_ctrl_q[`RDPC_B_AMP_CHOICE]; // R12
      O_GAIN_CODE <= amp_ctrl_q[`RDPC_B_AMP_CHOICE] ? gain_pair[7:4] :
                     gain_pair[3:0]; // R10
    end
  end

  // --------------------------------------------------------------
  // External amplifier control pin
  // --------------------------------------------------------------
  rdpc_ext_amp u_ext_amp (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_enable(ext_en_q[`RDPC_B_EXT_EN]), // R16
    .i_use_amp_on(amp_ctrl_q[`RDPC_B_TIMING]), // R13
    .i_invert(amp_ctrl_q[`RDPC_B_POL]), // R14
    .i_open_drain(amp_ctrl_q[`RDPC_B_DRIVE]), // R15
    .i_tx_on(I_TX_ON),
    .i_amp_on(I_AMP_ON),
    .o_pin_out(O_EXTERNAL_AMP_CONTROL_OUT),
    .o_pin_oe(O_EXTERNAL_AMP_CONTROL_OE)
  );

endmodule

// ### logic/rdpc_consts.svh
`ifndef RDPC_CONSTS_SVH
`define RDPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses = 4 * index)
// ----------------------------------------------------------------
`define RDPC_IDX_DEMOD 8'h01
`define RDPC_IDX_LVL_OFS 8'h02
`define RDPC_IDX_MON_OUT 8'h03
`define RDPC_IDX_GAIN1 8'h04
`define RDPC_IDX_GAIN2 8'h05
`define RDPC_IDX_GAIN3 8'h06
`define RDPC_IDX_AMP_CTRL 8'h07
`define RDPC_IDX_EXT_EN 8'h08
`define RDPC_IDX_STATUS 8'h09
`define RDPC_IDX_TEMP 8'h0a

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RDPC_RST_DEMOD 8'h00
`define RDPC_RST_LVL_OFS 8'h00
`define RDPC_RST_MON_OUT 8'h00
`define RDPC_RST_GAIN 8'h77
`define RDPC_RST_AMP_CTRL 8'h13
`define RDPC_RST_EXT_EN 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RDPC_B_BER 7
`define RDPC_B_STR_FREEZE 3
`define RDPC_B_LIM_DIS 2
`define RDPC_B_AFC_STOP 1
`define RDPC_B_AFC_DIS 0
`define RDPC_B_OFS_DIR 7
`define RDPC_B_TEMP_DIG 5
`define RDPC_B_TEMP_ANA 4
`define RDPC_B_RSSI_ANA 0
`define RDPC_B_TIMING 7
`define RDPC_B_POL 6
`define RDPC_B_DRIVE 5
`define RDPC_B_AMP_CHOICE 4
`define RDPC_B_EXT_EN 4

// ----------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------
`define RDPC_RESP_OKAY 2'b00
`define RDPC_RESP_SLVERR 2'b10

`endif

// ### logic/rdpc_pkg.sv
package rdpc_pkg;
  typedef logic [7:0] rdpc_byte_t;
  typedef enum logic [1:0] {
    RDPC_SEL_BAD,
    RDPC_SEL_ONE,
    RDPC_SEL_TWO,
    RDPC_SEL_THREE
  } rdpc_gain_sel_e;
  typedef enum {
    RDPC_W_IDLE,
    RDPC_W_RESP
  } rdpc_wr_state_e;
endpackage

// ### logic/rdpc_track_gate.sv
// ----------------------------------------------------------------
// Tracking gate: runs, or stops after a frame start when asked to
// ----------------------------------------------------------------
module rdpc_track_gate (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_rx_active,
  input wire logic i_sfd_det,
  input wire logic i_stop_after_sfd,
  input wire logic i_disable,
  // Result
  output logic o_run
);
  logic frozen_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      frozen_q <= 1'b0;
    end else if (!i_rx_active) begin
      frozen_q <= 1'b0;
    end else if (i_sfd_det) begin
      frozen_q <= 1'b1;
    end
  end

  always_comb begin
    o_run = !i_disable && !(i_stop_after_sfd && frozen_q);
  end
endmodule

// ### logic/rdpc_ext_amp.sv
// ----------------------------------------------------------------
// External amplifier control pin: timing, polarity, drive mode
// ----------------------------------------------------------------
module rdpc_ext_amp (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Settings
  input wire logic i_enable,
  input wire logic i_use_amp_on,
  input wire logic i_invert,
  input wire logic i_open_drain,
  // Radio states
  input wire logic i_tx_on,
  input wire logic i_amp_on,
  // Pin
  output logic o_pin_out,
  output logic o_pin_oe
);
  logic active;
  logic level;

  always_comb begin
    active = i_enable && (i_use_amp_on ? i_amp_on : i_tx_on); // R13 R16
    level = active ^ (i_enable && i_invert); // R14
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b1;
    end else begin
      o_pin_out <= i_open_drain ? 1'b0 : level;
      o_pin_oe <= i_open_drain ? !level : 1'b1; // R15
    end
  end
endmodule

// ### dv/rdpc_monitor.sv
module rdpc_monitor (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // Register bus
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  // Radio side
  input wire logic I_RX_ACTIVE,
  input wire logic O_SYMBOL_TIMING_RUN,
  input wire logic O_BIT_ERROR_MEASURE_MODE,
  input wire logic O_FREQ_CORR_LIMITER_EN,
  input wire logic O_AMPLIFIER_CHOICE,
  input wire logic [3:0] O_GAIN_CODE,
  input wire logic O_EXTERNAL_AMP_CONTROL_OUT,
  input wire logic O_EXTERNAL_AMP_CONTROL_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp lost");
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rdata lost");
  property p_w_ans;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> O_BVALID;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("no bvalid");
  property p_r_ans;
    I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("no rvalid");
  property p_r_upper;
    O_RVALID |-> O_RDATA[31:8] == 24'h0;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper set");
  property p_od_low;
    !O_EXTERNAL_AMP_CONTROL_OE |-> !O_EXTERNAL_AMP_CONTROL_OUT;
  endproperty
  a_od_low: assert property (p_od_low) else $error("od high");
  // Settings move only right after a register write lands
  property p_cfg_static;
    $changed({O_BIT_ERROR_MEASURE_MODE, O_FREQ_CORR_LIMITER_EN,
      O_AMPLIFIER_CHOICE, O_GAIN_CODE}) |-> $past(O_BVALID);
  endproperty
  a_cfg_static: assert property (p_cfg_static) else $error("cfg");
  property p_run_fall;
    $fell(O_SYMBOL_TIMING_RUN) |-> $past(I_RX_ACTIVE);
  endproperty
  a_run_fall: assert property (p_run_fall) else $error("freeze");
  c_write: cover property (O_BVALID && I_BREADY);
  c_read: cover property (O_RVALID && I_RREADY);
  c_freeze: cover property ($fell(O_SYMBOL_TIMING_RUN));
endmodule

// ### dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CORE_CLK, I_SYS_RST, I_AWVALID, O_AWREADY, I_WVALID, O_WREADY;
  logic O_BVALID, I_BREADY, I_ARVALID, O_ARREADY, O_RVALID, I_RREADY;
  logic I_RX_ACTIVE, I_SFD_DET, I_TX_ON, I_AMP_ON, O_BIT_ERROR_MEASURE_MODE;
  logic O_SYMBOL_TIMING_RUN, O_FREQ_CORR_LIMITER_EN, O_FREQ_CORR_RUN;
  logic O_TEMP_ANALOG_OUT_EN, O_SIGNAL_LEVEL_ANALOG_OUT_EN;
  logic O_RX_NOT_GUARANTEED, O_AMPLIFIER_CHOICE;
  logic O_EXTERNAL_AMP_CONTROL_OUT, O_EXTERNAL_AMP_CONTROL_OE;
  logic [31:0] I_AWADDR, I_WDATA, I_ARADDR, O_RDATA;
  logic [3:0] I_WSTRB, O_GAIN_CODE, e_gc;
  logic [1:0] O_BRESP, O_RRESP;
  logic [7:0] I_SIGNAL_LEVEL, I_TEMP_CONV, O_SIGNAL_LEVEL_ADJ, e_adj, a, d;
  logic [7:0] m [0:10];
  logic [7:0] mo [4] = '{8'h00, 8'h01, 8'h10, 8'h20};
  logic [7:0] dm [5] = '{8'h0a, 8'h00, 8'h01, 8'h08, 8'h02};
  logic [15:0] lf;
  logic e_lv, e_sym, e_fcr;
  int error_cnt, compares, seen, n;

  rdpc_top u_rdpc_top (.*);

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tmo();
    if (n >= 50) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, dt, input logic [3:0] s);
    bit ok_a, ok_w;
    ok_a = 0;
    ok_w = 0;
    n = 0;
    @(posedge I_CORE_CLK);
    I_AWVALID <= 1'b1;
    I_AWADDR <= {22'h0, ad, 2'b00};
    I_WVALID <= 1'b1;
    I_WDATA <= {lf, 8'h00, dt};
    I_WSTRB <= s;
    while (!(ok_a && ok_w) && n < 50) begin
      @(posedge I_CORE_CLK);
      n++;
      if (!ok_a && O_AWREADY) begin
        ok_a = 1;
        I_AWVALID <= 1'b0;
      end
      if (!ok_w && O_WREADY) begin
        ok_w = 1;
        I_WVALID <= 1'b0;
      end
    end
    tmo();
    I_BREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge I_CORE_CLK);
      n++;
    end while (!O_BVALID && n < 50);
    tmo();
    I_BREADY <= 1'b0;
    chk("bresp", (ad >= 1 && ad <= 8) ? 2'b00 : 2'b10, O_BRESP);
    if (ad >= 1 && ad <= 8 && s[0]) m[ad] = dt;
  endtask
  task automatic rd(input logic [7:0] ad);
    logic [31:0] e;
    e = (ad >= 1 && ad <= 10 && ad != 9) ? m[ad] : 32'h0;
    if (ad == 9) e = {29'h0, m[7][5] ? 1'b0 : e_lv, e_fcr, e_sym};
    n = 0;
    @(posedge I_CORE_CLK);
    I_ARVALID <= 1'b1;
    I_ARADDR <= {22'h0, ad, 2'b00};
    I_RREADY <= 1'b1;
    do begin
      @(posedge I_CORE_CLK);
      n++;
    end while (!O_ARREADY && n < 50);
    I_ARVALID <= 1'b0;
    while (!O_RVALID && n < 50) begin
      @(posedge I_CORE_CLK);
      n++;
    end
    tmo();
    I_RREADY <= 1'b0;
    chk("rdata", e, O_RDATA);
    chk("rresp", (ad >= 1 && ad <= 10) ? 2'b00 : 2'b10, O_RRESP);
  endtask
  task automatic stim();
    lf = nx(lf);
    I_TX_ON <= lf[0];
    I_AMP_ON <= lf[1];
    I_SIGNAL_LEVEL <= lf[15:8];
    I_TEMP_CONV <= lf[9:2];
  endtask
  task automatic cmp_all();
    logic [7:0] g;
    int v;
    repeat (3) @(posedge I_CORE_CLK);
    g = m[7][1:0] == 2'b01 ? m[4] : m[7][1:0] == 2'b10 ? m[5] : m[6];
    e_gc = m[7][4] ? g[7:4] : g[3:0];
    v = int'(I_SIGNAL_LEVEL) + (m[2][7] ? 1 : -1) * int'(m[2][4:0]);
    e_adj = v > 255 ? 8'hff : v < 0 ? 8'h00 : v[7:0];
    e_lv = m[8][4] & ((m[7][7] ? I_AMP_ON : I_TX_ON) ^ m[7][6]);
    e_sym = !(m[1][3] && seen);
    e_fcr = !(m[1][0] || (m[1][1] && seen));
    if (m[3][5]) m[10] = I_TEMP_CONV;
    chk("mode", m[1][7], O_BIT_ERROR_MEASURE_MODE);
    chk("sym", e_sym, O_SYMBOL_TIMING_RUN);
    chk("lim", !m[1][2], O_FREQ_CORR_LIMITER_EN);
    chk("fcr", e_fcr, O_FREQ_CORR_RUN);
    chk("adj", e_adj, O_SIGNAL_LEVEL_ADJ);
    chk("rxng", m[3][5], O_RX_NOT_GUARANTEED);
    chk("t_en", m[3][4], O_TEMP_ANALOG_OUT_EN);
    chk("l_en", m[3][0], O_SIGNAL_LEVEL_ANALOG_OUT_EN);
    chk("choice", m[7][4], O_AMPLIFIER_CHOICE);
    chk("gain", e_gc, O_GAIN_CODE);
    chk("pin", m[7][5] ? 1'b0 : e_lv, O_EXTERNAL_AMP_CONTROL_OUT);
    chk("oe", m[7][5] ? !e_lv : 1'b1, O_EXTERNAL_AMP_CONTROL_OE);
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    I_CORE_CLK = 1'b0;
    forever #4 I_CORE_CLK = ~I_CORE_CLK;
  end
  initial begin
    repeat (90000) @(posedge I_CORE_CLK);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = '0;
    {I_RX_ACTIVE, I_SFD_DET, I_TX_ON, I_AMP_ON} = '0;
    {I_AWADDR, I_WDATA, I_ARADDR, I_WSTRB} = '0;
    {I_SIGNAL_LEVEL, I_TEMP_CONV} = '0;
    I_SYS_RST = 1'b1;
    lf = 16'h0001;
    m = '{default: 8'h00};
    {m[4], m[5], m[6], m[7]} = {8'h77, 8'h77, 8'h77, 8'h13};
    repeat (2) @(posedge I_CORE_CLK);
    I_SYS_RST <= 1'b0;
    cmp_all();
    for (int k = 0; k < 12; k++) rd(8'(k));
    for (int k = 0; k < 128; k++) begin
      lf = nx(lf);
      // Gain select 00 is forbidden to software: map it to 01
      wr(8'h07, {k[2:0], k[3], lf[1:0], k[5:4] | {1'b0, k[5:4] == 2'b00}},
         4'h1);
      wr(8'h08, {lf[7:5], k[6], lf[3:0]}, 4'h1);
      lf = nx(lf);
      a = 8'h01 + {5'h0, lf[2:0]} % 8'h06;
      d = lf[15:8];
      if (a == 8'h03) d = (d & 8'hce) | mo[lf[4:3]];
      wr(a, d, 4'h1);
      stim();
      cmp_all();
      rd({4'h0, k[3:0]});
    end
    wr(8'h02, 8'h5a, 4'he);
    wr(8'h09, 8'hff, 4'h1);
    wr(8'h3f, 8'hff, 4'h1);
    rd(8'h02);
    foreach (dm[i]) begin
      wr(8'h01, dm[i], 4'h1);
      I_RX_ACTIVE <= 1'b1;
      @(posedge I_CORE_CLK);
      I_SFD_DET <= 1'b1;
      @(posedge I_CORE_CLK);
      I_SFD_DET <= 1'b0;
      seen = 1;
      cmp_all();
      rd(8'h09);
      I_RX_ACTIVE <= 1'b0;
      seen = 0;
      cmp_all();
    end
    wrap_up();
  end
endmodule

bind rdpc_top rdpc_monitor u_rdpc_monitor (.*);
